// ### hdl/selector_defs.vh
`ifndef SELECTOR_DEFS_VH
`define SELECTOR_DEFS_VH

// Clock rate
`define CLK_HZ 125000000

// Press timing, in milliseconds
`define ENTRY_HOLD_MS 10000
`define EXIT_HOLD_MS 5000
`define DEBOUNCE_MS 20
`define BLINK_HALF_MS 200

// Synchroniser depth, in cycles
`define SYNC_LAT 32'h2

// Derived cycle counts
`define ENTRY_HOLD_CYC (`ENTRY_HOLD_MS * (`CLK_HZ / 1000))
`define EXIT_HOLD_CYC (`EXIT_HOLD_MS * (`CLK_HZ / 1000))
`define DEBOUNCE_CYC (`DEBOUNCE_MS * (`CLK_HZ / 1000))
`define BLINK_HALF_CYC (`BLINK_HALF_MS * (`CLK_HZ / 1000))

// Confirmation blinks
`define BLINK_COUNT 3

// Selection indices
`define SEL_EXIT 2'h0
`define SEL_RECOVERY 2'h1
`define SEL_FLASH 2'h2
`define SEL_PROFILE 2'h3

// Display codes, two BCD digits
`define CODE_EXIT 8'h51
`define CODE_RECOVERY 8'h55
`define CODE_FLASH 8'h56
`define CODE_PROFILE 8'h57

// LED patterns {activity, speed, duplex}
`define LED_EXIT 3'h1
`define LED_RECOVERY 3'h5
`define LED_FLASH 3'h6
`define LED_PROFILE 3'h7

`endif

// ### hdl/button_conditioner.v
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser followed by a stability debouncer
module button_conditioner #(
    parameter [31:0] DEBOUNCE_CYC = 32'd2500000
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire button_n_i,
    output reg pressed_o
);

reg sync1_q;
reg sync2_q;
reg [31:0] stable_q;

// Synchroniser on the raw pin; reset to the released level, so no false press
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        sync1_q <= 1'b1;
        sync2_q <= 1'b1;
    end else begin
        sync1_q <= button_n_i;
        sync2_q <= sync1_q;
    end
end

// Accept a new level only after it stays put for the whole window
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        stable_q <= 32'h0;
        pressed_o <= 1'b0;
    end else if (~sync2_q == pressed_o) begin
        stable_q <= 32'h0;
    end else if (stable_q >= DEBOUNCE_CYC - 32'd1) begin
        stable_q <= 32'h0;
        pressed_o <= ~sync2_q;
    end else begin
        stable_q <= stable_q + 32'd1;
    end
end

endmodule // button_conditioner

`default_nettype wire

// ### hdl/button_function_selector.v
`timescale 1ns/1ns
`default_nettype none
`include "selector_defs.vh"

module button_function_selector #(
    parameter [31:0] ENTRY_HOLD_CYC = `ENTRY_HOLD_CYC,
    parameter [31:0] EXIT_HOLD_CYC = `EXIT_HOLD_CYC,
    parameter [31:0] DEBOUNCE_CYC = `DEBOUNCE_CYC,
    parameter [31:0] BLINK_HALF_CYC = `BLINK_HALF_CYC
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire button_n_i,
    output reg activity_indicator_o,
    output reg speed_indicator_o,
    output reg duplex_indicator_o,
    output reg [7:0] display_code_o,
    output reg display_on_o,
    output reg mode_active_o,
    output reg func_valid_o,
    output reg [1:0] func_sel_o
);

// Controller states
localparam [2:0] ST_POWERUP = 3'h0;
localparam [2:0] ST_BLINK = 3'h1;
localparam [2:0] ST_SELECT = 3'h2;
localparam [2:0] ST_DONE = 3'h3;
localparam [2:0] ST_NORMAL = 3'h4;

wire pressed;
reg [2:0] state_q;
reg [2:0] state_d;
reg [31:0] hold_q;
reg [31:0] hold_d;
reg [31:0] blink_tmr_q;
reg [31:0] blink_tmr_d;
reg [2:0] blink_cnt_q;
reg [2:0] blink_cnt_d;
reg blink_on_q;
reg blink_on_d;
reg [1:0] sel_q;
reg [1:0] sel_d;
reg long_done_q;
reg long_done_d;
reg pressed_prev_q;
reg [2:0] leds;
reg [7:0] code;
wire release_seen;
wire exit_req;
wire [2:0] lamp_d;

// Raw pin goes straight into the synchroniser; inversion happens after it
button_conditioner #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC)
) u_cond (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .button_n_i(button_n_i),
    .pressed_o(pressed)
);

// Debounced level needs this long to follow a pin held through reset
localparam [31:0] SETTLE_CYC = DEBOUNCE_CYC + `SYNC_LAT;

// Debounced release edge
assign release_seen = !pressed && pressed_prev_q;

// Pattern and code of the next choice, so lamps and code move together
always @* begin
    case (sel_d)
        `SEL_EXIT: begin
            leds = `LED_EXIT;
            code = `CODE_EXIT;
        end
        `SEL_RECOVERY: begin
            leds = `LED_RECOVERY;
            code = `CODE_RECOVERY;
        end
        `SEL_FLASH: begin
            leds = `LED_FLASH;
            code = `CODE_FLASH;
        end
        default: begin
            leds = `LED_PROFILE;
            code = `CODE_PROFILE;
        end
    endcase
end

// Next-state logic
always @* begin
    state_d = state_q;
    hold_d = hold_q;
    blink_tmr_d = blink_tmr_q;
    blink_cnt_d = blink_cnt_q;
    blink_on_d = blink_on_q;
    sel_d = sel_q;
    long_done_d = long_done_q;
    case (state_q)
        ST_POWERUP: begin
            // Pressed reads low until the conditioner settles; judge only after
            if (!pressed && hold_q >= SETTLE_CYC) begin
                state_d = ST_NORMAL;
            end else if (pressed && hold_q >= ENTRY_HOLD_CYC) begin
                state_d = ST_BLINK;
                hold_d = 32'h0;
                blink_tmr_d = 32'h0;
                blink_cnt_d = 3'h0;
                blink_on_d = 1'b1;
                sel_d = `SEL_EXIT;
                long_done_d = 1'b1;
            end else begin
                hold_d = hold_q + 32'd1;
            end
        end
        ST_BLINK: begin
            if (blink_tmr_q >= BLINK_HALF_CYC - 32'd1) begin
                blink_tmr_d = 32'h0;
                blink_on_d = ~blink_on_q;
                // Each dark half that ends closes one flash
                if (!blink_on_q && blink_cnt_q == (`BLINK_COUNT - 1)) begin
                    state_d = ST_SELECT;
                end else if (blink_on_q) begin
                    blink_on_d = 1'b0;
                end else begin
                    blink_cnt_d = blink_cnt_q + 3'd1;
                end
            end else begin
                blink_tmr_d = blink_tmr_q + 32'd1;
            end
        end
        ST_SELECT: begin
            // The entry hold is still down at first; ignore it until release
            if (!pressed) begin
                hold_d = 32'h0;
                // Release of a short press steps on
                if (release_seen && !long_done_q) begin
                    if (sel_q == `SEL_PROFILE) begin
                        sel_d = `SEL_EXIT;
                    end else begin
                        sel_d = sel_q + 2'd1;
                    end
                end
                long_done_d = 1'b0;
            end else if (!long_done_q) begin
                if (hold_q >= EXIT_HOLD_CYC - 32'd1) begin
                    state_d = ST_DONE;
                end else begin
                    hold_d = hold_q + 32'd1;
                end
            end
        end
        ST_DONE: begin
            // Request issued; only a reset leaves here
            state_d = ST_DONE;
        end
        default: begin
            // Normal start; the button has no say here
            state_d = ST_NORMAL;
        end
    endcase
end

// Controller state; every reset restarts the power-up timing
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        state_q <= ST_POWERUP;
    end else begin
        state_q <= state_d;
    end
end

// Hold timer, shared by the entry and exit holds
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        hold_q <= 32'h0;
    end else begin
        hold_q <= hold_d;
    end
end

// Flash half-period timer
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        blink_tmr_q <= 32'h0;
    end else begin
        blink_tmr_q <= blink_tmr_d;
    end
end

// Flash count and lamp phase
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        blink_cnt_q <= 3'h0;
        blink_on_q <= 1'b0;
    end else begin
        blink_cnt_q <= blink_cnt_d;
        blink_on_q <= blink_on_d;
    end
end

// Current choice
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        sel_q <= `SEL_EXIT;
    end else begin
        sel_q <= sel_d;
    end
end

// Masks the entry hold so it never counts as an exit hold
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        long_done_q <= 1'b0;
    end else begin
        long_done_q <= long_done_d;
    end
end

// Last debounced level, for the release edge
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        pressed_prev_q <= 1'b0;
    end else begin
        pressed_prev_q <= pressed;
    end
end

// Next lamp levels, one slice per indicator {activity, speed, duplex}
genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_lamp
        assign lamp_d[gi] = (state_d == ST_BLINK) ? blink_on_d :
            ((state_d == ST_SELECT) ? leds[gi] : 1'b0);
    end
endgenerate

// Indicator flops; all lit in the flash, the pattern while selecting
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        activity_indicator_o <= 1'b0;
        speed_indicator_o <= 1'b0;
        duplex_indicator_o <= 1'b0;
    end else begin
        activity_indicator_o <= lamp_d[2];
        speed_indicator_o <= lamp_d[1];
        duplex_indicator_o <= lamp_d[0];
    end
end

// Display dark outside the selection, code of the choice inside it
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        display_code_o <= 8'h00;
        display_on_o <= 1'b0;
    end else if (state_d == ST_SELECT) begin
        display_code_o <= code;
        display_on_o <= 1'b1;
    end else begin
        display_code_o <= 8'h00;
        display_on_o <= 1'b0;
    end
end

// Mode flag covers both the flash and the selection
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        mode_active_o <= 1'b0;
    end else begin
        mode_active_o <= (state_d == ST_BLINK) || (state_d == ST_SELECT);
    end
end

// Leaving the selection with the choice still standing
assign exit_req = (state_q == ST_SELECT) && (state_d == ST_DONE);

// One-cycle request; the chosen function stays on its pins until reset
always @(posedge sys_clk_i) begin
    if (rst_i) begin
        func_valid_o <= 1'b0;
        func_sel_o <= 2'h0;
    end else if (exit_req) begin
        func_valid_o <= 1'b1;
        func_sel_o <= sel_q;
    end else begin
        func_valid_o <= 1'b0;
    end
end

endmodule // button_function_selector

`default_nettype wire

// ### sim/button_operator.sv
`timescale 1ns/1ns
`default_nettype none
// Operator at the push button; the pin idles high on its pull-up
module button_operator (
    input wire logic sys_clk_i,
    output logic button_n_o
);
    initial button_n_o = 1'b1;
    // Press and hold, changed on the falling edge
    task automatic down();
        @(negedge sys_clk_i);
        button_n_o = 1'b0;
    endtask
    // Let go; the pull-up takes the pin high
    task automatic up();
        @(negedge sys_clk_i);
        button_n_o = 1'b1;
    endtask
    // Press for k cycles
    task automatic press(input int k);
        down();
        repeat (k - 1) @(negedge sys_clk_i);
        up();
    endtask
    // Contact chatter, far shorter than the settling window
    task automatic bounce();
        repeat (3) press(1);
    endtask
endmodule // button_operator
`default_nettype wire

// ### sim/button_selector_chk.sv
`timescale 1ns/1ns
`default_nettype none
// Pin-level checks on the selector
module button_selector_chk #(
    parameter [31:0] ENTRY_HOLD_CYC = 32'd200,
    parameter [31:0] EXIT_HOLD_CYC = 32'd100
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic button_n_i,
    input wire logic activity_indicator_o,
    input wire logic speed_indicator_o,
    input wire logic duplex_indicator_o,
    input wire logic [7:0] display_code_o,
    input wire logic display_on_o,
    input wire logic mode_active_o,
    input wire logic func_valid_o,
    input wire logic [1:0] func_sel_o
);
    logic [31:0] low_q;
    wire logic [2:0] led = {activity_indicator_o, speed_indicator_o, duplex_indicator_o};
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Raw pin low run; includes sync and settle delay, so it only over-counts
    always @(posedge sys_clk_i) begin
        low_q <= (rst_i || button_n_i) ? 32'h0 : low_q + 32'h1;
    end
    // Opening flash
    sequence all_lit;
        (led == 3'h7) [*8];
    endsequence
    a_entry_hold: assert property ($rose(mode_active_o) |-> low_q > ENTRY_HOLD_CYC)
        else $error("mode entered early");
    a_blink_lit: assert property ($rose(mode_active_o) |-> ##[0:2] all_lit)
        else $error("no opening flash");
    a_first_code: assert property ($rose(display_on_o) |-> display_code_o == 8'h51)
        else $error("wrong first code");
    a_exit_hold: assert property ($rose(func_valid_o) |-> low_q >= EXIT_HOLD_CYC)
        else $error("exit too soon");
    a_pulse_done: assert property (func_valid_o |=> !func_valid_o && !mode_active_o)
        else $error("exit pulse wrong");
    a_code_51: assert property (display_code_o == 8'h51 |-> led == 3'h1)
        else $error("pattern for 51");
    a_code_55: assert property (display_code_o == 8'h55 |-> led == 3'h5)
        else $error("pattern for 55");
    a_code_56: assert property (display_code_o == 8'h56 |-> led == 3'h6)
        else $error("pattern for 56");
    a_code_57: assert property (display_code_o == 8'h57 |-> led == 3'h7)
        else $error("pattern for 57");
endmodule // button_selector_chk
bind button_function_selector button_selector_chk #(.ENTRY_HOLD_CYC(ENTRY_HOLD_CYC),
    .EXIT_HOLD_CYC(EXIT_HOLD_CYC)) chk_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .button_n_i(button_n_i), .activity_indicator_o(activity_indicator_o),
    .speed_indicator_o(speed_indicator_o), .duplex_indicator_o(duplex_indicator_o),
    .display_code_o(display_code_o), .display_on_o(display_on_o),
    .mode_active_o(mode_active_o), .func_valid_o(func_valid_o), .func_sel_o(func_sel_o));
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
// Selector bench with shortened hold times
module tb;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hit;
    wire logic button_n_i;
    wire logic [2:0] led_w;
    wire logic [7:0] code_w;
    wire logic [1:0] fsel_w;
    wire logic on_w, mode_w, fv_w;
    int num_errors = 0, cmp_count = 0, sel, blinks, i, n, r;
    logic [7:0] code_t [4] = '{8'h51, 8'h55, 8'h56, 8'h57};
    logic [2:0] led_t [4] = '{3'h1, 3'h5, 3'h6, 3'h7};

    button_function_selector #(.ENTRY_HOLD_CYC(32'd200), .EXIT_HOLD_CYC(32'd100),
        .DEBOUNCE_CYC(32'd4), .BLINK_HALF_CYC(32'd10)) dut_u (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .button_n_i(button_n_i), .activity_indicator_o(led_w[2]),
        .speed_indicator_o(led_w[1]), .duplex_indicator_o(led_w[0]),
        .display_code_o(code_w), .display_on_o(on_w), .mode_active_o(mode_w),
        .func_valid_o(fv_w), .func_sel_o(fsel_w));
    button_operator op_u (.sys_clk_i(sys_clk_i), .button_n_o(button_n_i));

    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // Count all-on flashes before the selection opens
    always @(posedge sys_clk_i) begin
        if (mode_w && !on_w && led_w == 3'h7 && $past(led_w) != 3'h7) blinks++;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // A wait that ran out ends the run
    task automatic limit(input int k);
        if (k >= 300) begin
            num_errors++;
            wrap_up();
        end
    endtask
    // Power up with the button already down, let go k+1 cycles after reset
    task automatic power_up(input int k);
        rst_i = 1'b1;
        op_u.down();
        repeat (20) @(negedge sys_clk_i);
        rst_i = 1'b0;
        blinks = 0;
        repeat (k) @(negedge sys_clk_i);
        op_u.up();
    endtask
    initial begin
        n = $urandom(68);
        // Too short a hold keeps normal operation
        power_up(150);
        hit = 1'b0;
        repeat (400) begin
            @(negedge sys_clk_i);
            hit = hit | mode_w;
        end
        chk({7'h0, hit}, 8'h0);
        for (r = 0; r < 2; r++) begin
            power_up(230);
            for (i = 0; i < 300 && on_w !== 1'b1; i++) @(negedge sys_clk_i);
            limit(i);
            repeat (3) @(negedge sys_clk_i);
            chk(8'(blinks), 8'h3);
            sel = 0;
            n = r ? $urandom % 8 : 5;
            // Step through choices; first pass wraps past the last one
            for (int p = 0; p <= n; p++) begin
                chk(code_w, code_t[sel]);
                chk({5'h0, led_w}, {5'h0, led_t[sel]});
                if (p < n) begin
                    op_u.press(20 + $urandom % 40);
                    sel = (sel + 1) % 4;
                    repeat (20) @(negedge sys_clk_i);
                end
            end
            op_u.bounce();
            repeat (20) @(negedge sys_clk_i);
            chk(code_w, code_t[sel]);
            // Long hold leaves and requests the shown choice
            op_u.down();
            for (i = 0; i < 300 && fv_w !== 1'b1; i++) @(negedge sys_clk_i);
            limit(i);
            chk({6'h0, fsel_w}, 8'(sel));
            @(negedge sys_clk_i);
            chk({7'h0, mode_w}, 8'h0);
            op_u.up();
        end
        wrap_up();
    end
endmodule // tb
`default_nettype wire
